// ---- rtl/eebc_top.sv ----
`timescale 1ns/1ps
module eebc_top
#(
  parameter int SIG_W = 32
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_error,
  output logic reg_wait,
  input wire eebc_pkg::eebc_req_t mem_req,
  output logic [31:0] mem_rdata,
  output logic mem_ready,
  output logic mem_error,
  output logic [15:0] last_read_word
);
  import eebc_pkg::*;

  typedef enum {ST_IDLE, ST_READ, ST_PROG, ST_SUM} eebc_state_t;

  // storage and page buffer
  // rows of half-word cells, flat index
  logic [15:0] array_mem [EEBC_WORDS];
  logic [15:0] page_buf [EEBC_ROW_WORDS];
  logic [EEBC_ROW_WORDS-1:0] page_mask;
  logic [5:0] page_row;
  logic [15:0] next_word_val;
  // control registers
  logic [2:0] command;
  logic [15:0] rd_wait;
  logic [1:0] auto_mode;
  logic [31:0] wr_wait;
  logic [31:0] clk_div;
  logic [31:0] pwr_down;
  logic [10:0] sum_start;
  logic [10:0] sum_stop;
  logic [SIG_W-1:0] data_sig;
  logic [SIG_W-1:0] par_sig;
  logic [31:0] irq_en;
  logic [31:0] irq_st;
  // sequencer
  eebc_state_t state;
  eebc_state_t next_state;
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [1:0] part;
  logic [1:0] next_part;
  logic [31:0] rd_acc;
  logic [31:0] next_rd_acc;
  logic [10:0] sum_idx;
  logic [10:0] next_sum_idx;
  logic [10:0] widx;
  logic [1:0] nparts;
  logic start_prog;
  logic start_sum;
  logic done_prog;
  logic lock_row;
  logic bus_wr_ok;
  logic [31:0] rd_mux;
  logic [15:0] rd_word;

  // word index for byte address plus part offset
  function automatic logic [10:0] word_of(input logic [11:0] a, input logic [1:0] p);
    word_of = a[11:1] + {9'h000, p};
  endfunction : word_of

  // read length, two minus-one encoded phases, counted down to zero
  function automatic logic [9:0] read_len(input logic [15:0] w);
    read_len = 10'(w[7:0]) + 10'(w[15:8]) + 10'h001;
  endfunction : read_len

  // program length, three minus-one encoded phases, counted down to zero
  function automatic logic [9:0] prog_len(input logic [31:0] w);
    prog_len = 10'(w[7:0]) + 10'(w[15:8]) + 10'(w[23:16]) + 10'h002;
  endfunction : prog_len

  assign widx = word_of(mem_req.addr, 2'h0);
  // number of 16-bit reads per access size
  assign nparts = (mem_req.size == 2'h2) ? 2'h2 : 2'h1;
  assign lock_row = (widx[10:5] >= 6'(EEBC_ROWS - EEBC_LOCKED_ROWS));
  assign rd_word = array_mem[word_of(mem_req.addr, part)];

  // command write during program errors, a program command waits during read or walk
  assign start_prog = reg_wr && reg_addr == REG_COMMAND && reg_wdata[2:0] == CMD_PROGRAM
                      && state == ST_IDLE;
  assign reg_wait = reg_wr && reg_addr == REG_COMMAND && reg_wdata[2:0] == CMD_PROGRAM
                    && (state == ST_READ || state == ST_SUM);
  assign reg_error = reg_wr && reg_addr == REG_COMMAND && state == ST_PROG;
  // checksum is kicked by writing the stop address while idle
  assign start_sum = reg_wr && reg_addr == REG_SUM_STOP && state == ST_IDLE;
  // a buffered write completes in one cycle when idle
  assign bus_wr_ok = mem_req.sel && mem_req.write && state == ST_IDLE && !lock_row;

  // data port answers
  always_comb
  begin
    mem_ready = 1'b0;
    mem_error = 1'b0;
    mem_rdata = rd_acc;
    if (mem_req.sel)
    begin
      if (state == ST_PROG)
        mem_error = 1'b1;
      else if (mem_req.write)
      begin
        // a locked row answers with error only, never with ready
        mem_ready = (state == ST_IDLE) && !lock_row;
        mem_error = (state == ST_IDLE) && lock_row;
      end
      // read ends once all parts fetched
      else if (state == ST_READ && cnt == 10'h000 && part == nparts - 2'h1)
      begin
        mem_ready = 1'b1;
        mem_rdata = next_rd_acc;
      end
    end
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_part = part;
    next_rd_acc = rd_acc;
    next_sum_idx = sum_idx;
    done_prog = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        // program on command or auto trigger
        // a command beats a read starting in the same cycle; that read
        // then meets the busy array and takes the error answer
        if (start_prog || (bus_wr_ok && (auto_mode == AUTO_EACH
            || (auto_mode == AUTO_ROW_END && widx[4:0] == 5'h1f))))
        begin
          next_state = ST_PROG;
          next_cnt = prog_len(wr_wait);
        end
        // start the signature walk, a pending read waits behind it
        else if (start_sum)
        begin
          next_state = ST_SUM;
          next_sum_idx = sum_start;
        end
        else if (mem_req.sel && !mem_req.write)
        begin
          next_state = ST_READ;
          next_part = 2'h0;
          next_cnt = read_len(rd_wait);
        end
      end
      ST_READ:
      begin
        if (cnt != 10'h000)
          next_cnt = cnt - 10'h001;
        else
        begin
          // place each part in its lane
          if (part == 2'h0)
            next_rd_acc = (mem_req.size == 2'h0 && mem_req.addr[0])
                          ? {24'h000000, rd_word[15:8]} : {16'h0000, rd_word};
          else
            next_rd_acc = {rd_word, rd_acc[15:0]};
          if (part == nparts - 2'h1 || !mem_req.sel)
            next_state = ST_IDLE;
          else
          begin
            // next half word of a wide read
            next_part = part + 2'h1;
            next_cnt = read_len(rd_wait);
          end
        end
      end
      ST_PROG:
      begin
        // array stays busy until the count runs out
        if (cnt != 10'h000)
          next_cnt = cnt - 10'h001;
        else
        begin
          next_state = ST_IDLE;
          done_prog = 1'b1;
        end
      end
      ST_SUM:
      begin
        // one word per cycle up to the stop index
        if (sum_idx >= sum_stop)
          next_state = ST_IDLE;
        else
          next_sum_idx = sum_idx + 11'h001;
      end
    endcase
  end

  // merged byte lanes for a buffered write
  always_comb
  begin
    next_word_val = page_buf[widx[4:0]];
    // a byte write touches one lane only
    if (mem_req.size == 2'h0)
    begin
      if (mem_req.addr[0])
        next_word_val[15:8] = mem_req.wdata[15:8];
      else
        next_word_val[7:0] = mem_req.wdata[7:0];
    end
    else
      next_word_val = mem_req.wdata[15:0];
  end

  // sequencer registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cnt <= 10'h000;
      part <= 2'h0;
      rd_acc <= 32'h0000_0000;
      sum_idx <= 11'h000;
      last_read_word <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      part <= next_part;
      rd_acc <= next_rd_acc;
      sum_idx <= next_sum_idx;
      // flag view keeps the whole word
      if (state == ST_READ && cnt == 10'h000)
        last_read_word <= rd_word;
    end
  end

  // page buffer and array
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      page_mask <= '0;
      page_row <= 6'h00;
    end
    else
    begin
      // capture written word and mark its offset
      if (bus_wr_ok)
      begin
        page_buf[widx[4:0]] <= next_word_val;
        page_mask[widx[4:0]] <= 1'b1;
        page_row <= widx[10:5];
      end
      // commit marked words as one page, then clear
      if (done_prog)
      begin
        // unmarked words keep their old content
        for (int i = 0; i < EEBC_ROW_WORDS; i++)
          if (page_mask[i])
            array_mem[{page_row, 5'(i)}] <= page_buf[i];
        page_mask <= '0;
      end
    end
  end

  // register file and signatures
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      command <= 3'h0;
      rd_wait <= RD_WAIT_RESET;
      auto_mode <= AUTO_OFF;
      wr_wait <= WR_WAIT_RESET;
      clk_div <= 32'h0000_0000;
      pwr_down <= 32'h0000_0000;
      sum_start <= 11'h000;
      sum_stop <= 11'h000;
      data_sig <= '0;
      par_sig <= '0;
      irq_en <= 32'h0000_0000;
      irq_st <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr)
      begin
        unique case (reg_addr)
          // command is ignored while a program runs
          REG_COMMAND: if (state != ST_PROG) command <= reg_wdata[2:0];
          REG_RD_WAIT: rd_wait <= reg_wdata[15:0];
          // code 11b is kept as written, software avoids it
          REG_AUTO_PROG: auto_mode <= reg_wdata[1:0];
          // lock freezes write timing and clock divider (read wait stays writable), sticks until reset
          REG_WR_WAIT: if (!wr_wait[TIMING_LOCK_BIT])
            wr_wait <= {reg_wdata[31], 7'h00, reg_wdata[23:0]};
          REG_CLK_DIV: if (!wr_wait[TIMING_LOCK_BIT])
            clk_div <= {reg_wdata[31:30], 14'h0000, reg_wdata[15:0]};
          // only the enable bit is kept
          REG_PWR_DOWN: pwr_down <= {31'h0, reg_wdata[0]};
          REG_SUM_START: sum_start <= reg_wdata[10:0];
          // writing the stop index while idle also kicks the walk
          REG_SUM_STOP: sum_stop <= reg_wdata[10:0];
          REG_IRQ_EN_SET: irq_en <= irq_en | (reg_wdata & IRQ_MASK);
          REG_IRQ_EN_CLR: irq_en <= irq_en & ~reg_wdata;
          default: ;
        endcase
      end
      irq_st <= ((reg_wr && reg_addr == REG_IRQ_ST_CLR) ? irq_st & ~reg_wdata : irq_st)
                | ((reg_wr && reg_addr == REG_IRQ_ST_SET) ? reg_wdata & IRQ_MASK : 32'h0)
                | (32'(done_prog) << IRQ_PROG_DONE_BIT)
                | (32'(state == ST_SUM && sum_idx >= sum_stop) << IRQ_SUM_DONE_BIT);
      // fold each word into the signatures
      if (start_sum)
      begin
        data_sig <= '0;
        par_sig <= '0;
      end
      else if (state == ST_SUM)
      begin
        data_sig <= {data_sig[SIG_W-2:0], data_sig[SIG_W-1]}
                    ^ SIG_W'(array_mem[sum_idx]);
        par_sig <= {par_sig[SIG_W-2:0], par_sig[SIG_W-1] ^ (^array_mem[sum_idx])};
      end
    end
  end

  // register read mux
  always_comb
  begin
    unique case (reg_addr)
      REG_COMMAND: rd_mux = {29'h0, command};
      REG_RD_WAIT: rd_mux = {16'h0000, rd_wait};
      REG_AUTO_PROG: rd_mux = {30'h0, auto_mode};
      REG_WR_WAIT: rd_mux = wr_wait;
      REG_CLK_DIV: rd_mux = clk_div;
      REG_PWR_DOWN: rd_mux = pwr_down;
      REG_SUM_START: rd_mux = {21'h0, sum_start};
      REG_SUM_STOP: rd_mux = {21'h0, sum_stop};
      REG_DATA_SIG: rd_mux = 32'(data_sig);
      REG_PAR_SIG: rd_mux = 32'(par_sig);
      // status view: busy, read, program, walk
      REG_DEV_STATUS: rd_mux = {28'h0, state == ST_SUM, state == ST_PROG,
                                state == ST_READ, state != ST_IDLE};
      REG_CONFIG: rd_mux = CONFIG_VALUE;
      REG_IRQ_STATUS: rd_mux = irq_st;
      REG_IRQ_EN_VIEW: rd_mux = irq_en;
      REG_IDENTITY: rd_mux = IDENTITY_VALUE;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data one cycle after strobe
  // value holds until the next read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end
endmodule : eebc_top

// ---- common/eebc_pkg.sv ----
package eebc_pkg;
  localparam int EEBC_ROWS = 64;
  localparam int EEBC_ROW_WORDS = 32;
  localparam int EEBC_WORDS = EEBC_ROWS * EEBC_ROW_WORDS;
  localparam int EEBC_LOCKED_ROWS = 4;
  localparam logic [11:0] REG_COMMAND = 12'h000;
  localparam logic [11:0] REG_RD_WAIT = 12'h008;
  localparam logic [11:0] REG_AUTO_PROG = 12'h00c;
  localparam logic [11:0] REG_WR_WAIT = 12'h010;
  localparam logic [11:0] REG_CLK_DIV = 12'h014;
  localparam logic [11:0] REG_PWR_DOWN = 12'h018;
  localparam logic [11:0] REG_SUM_START = 12'h020;
  localparam logic [11:0] REG_SUM_STOP = 12'h024;
  localparam logic [11:0] REG_DATA_SIG = 12'h028;
  localparam logic [11:0] REG_PAR_SIG = 12'h02c;
  localparam logic [11:0] REG_DEV_STATUS = 12'h034;
  localparam logic [11:0] REG_CONFIG = 12'hfd0;
  localparam logic [11:0] REG_IRQ_EN_CLR = 12'hfd8;
  localparam logic [11:0] REG_IRQ_EN_SET = 12'hfdc;
  localparam logic [11:0] REG_IRQ_STATUS = 12'hfe0;
  localparam logic [11:0] REG_IRQ_EN_VIEW = 12'hfe4;
  localparam logic [11:0] REG_IRQ_ST_CLR = 12'hfe8;
  localparam logic [11:0] REG_IRQ_ST_SET = 12'hfec;
  localparam logic [11:0] REG_IDENTITY = 12'hffc;
  // command code and auto modes
  localparam logic [2:0] CMD_PROGRAM = 3'h6;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_EACH = 2'h1;
  localparam logic [1:0] AUTO_ROW_END = 2'h2;
  // field positions
  localparam int TIMING_LOCK_BIT = 31;
  localparam int IRQ_PROG_DONE_BIT = 2;
  localparam int IRQ_SUM_DONE_BIT = 3;
  localparam logic [31:0] IRQ_MASK = 32'h0000_000c;
  // reset values
  localparam logic [15:0] RD_WAIT_RESET = 16'h0101;
  localparam logic [31:0] WR_WAIT_RESET = 32'h0003_0303;
  localparam logic [31:0] IDENTITY_VALUE = 32'h0000_5a01; // arbitrary value
  localparam logic [31:0] CONFIG_VALUE = 32'h0000_0000;
  // data port answers
  typedef enum logic [1:0] {EEBC_OK, EEBC_WAIT, EEBC_ERR} eebc_resp_t;
  // data port request bundle
  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } eebc_req_t;
endpackage : eebc_pkg

// ---- verif/eebc_asserts.sv ----
`timescale 1ns/1ps
// port checks on the controller
module eebc_asserts
  import eebc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_error,
  input wire logic reg_wait,
  input wire eebc_pkg::eebc_req_t mem_req,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic mem_error
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // program command taken this cycle
  logic cmd_go;
  assign cmd_go = reg_wr && reg_addr == REG_COMMAND && reg_wdata[2:0] == CMD_PROGRAM
    && !reg_error && !reg_wait;
  property p_err_cause;
    reg_error |-> reg_wr && reg_addr == REG_COMMAND;
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("command error without command write");
  property p_one_answer;
    !(mem_ready && mem_error);
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("ready and error together");
  property p_answer_sel;
    (mem_ready || mem_error) |-> mem_req.sel;
  endproperty
  a_answer_sel: assert property (p_answer_sel)
    else $error("answer without request");
  property p_locked;
    mem_req.sel && mem_req.write && mem_req.addr >= 12'hf00 |-> !mem_ready;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked row write accepted");
  property p_read_wait;
    $rose(mem_req.sel) && !mem_req.write |-> (!mem_ready) [*2];
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answered too early");
  property p_prog_blocks;
    cmd_go |=> (!(mem_req.sel && mem_ready)) [*5];
  endproperty
  a_prog_blocks: assert property (p_prog_blocks)
    else $error("data port served while programming");
  property p_rdata_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_ident;
    reg_rd && reg_addr == REG_IDENTITY |=> reg_rdata == IDENTITY_VALUE;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity word wrong");
  property p_en_set;
    reg_wr && reg_addr == REG_IRQ_EN_SET ##2 reg_rd && reg_addr == REG_IRQ_EN_VIEW
      |=> (reg_rdata & $past(reg_wdata, 3) & IRQ_MASK) == ($past(reg_wdata, 3) & IRQ_MASK);
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable set not visible");
  c_prog: cover property (cmd_go);
  c_err: cover property (mem_error);
  c_read: cover property (mem_ready && !mem_req.write);
endmodule : eebc_asserts

// ---- verif/eebc_master.sv ----
`timescale 1ns/1ps
// processor-side master on the data port
module eebc_master
  import eebc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mem_ready,
  input wire logic mem_error,
  output eebc_pkg::eebc_req_t mem_req
);
  // bus idle at start
  initial mem_req = '0;
  // request held until answered or 300 cycles pass, then released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [1:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    repeat ($urandom_range(2)) @(posedge clk_sys);
    @(posedge clk_sys);
    mem_req <= '{sel: 1'b1, write: w, addr: a, size: s, wdata: d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!(mem_ready || mem_error) && n < 300);
    // released lines other than size stop showing old values
    mem_req <= '{sel: 1'b0, write: ~w, addr: ~a, size: s, wdata: ~d};
  endtask : xfer
endmodule : eebc_master

// ---- verif/eebc_top_bench.sv ----
`timescale 1ns/1ps
// self-checking bench for the controller
module eebc_top_bench;
  import eebc_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic reg_error;
  logic reg_wait;
  eebc_req_t mem_req;
  logic [31:0] mem_rdata;
  logic mem_ready;
  logic mem_error;
  logic [63:0] reg_q[$]; // mask and value per read
  logic [64:0] mem_q[$]; // error, mask and value per transfer
  logic [64:0] m;
  logic rd_d;
  logic err;
  logic [31:0] d;
  logic [11:0] a;
  logic [15:0] last_word;
  int fail_count;
  int samples_checked;
  eebc_top dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_error, .reg_wait, .mem_req, .mem_rdata, .mem_ready, .mem_error,
    .last_read_word(last_word));
  eebc_master u_master (.clk_sys, .mem_ready, .mem_error, .mem_req);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] k);
    samples_checked++;
    if ((g & k) !== (e & k))
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g & k, e & k);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [31:0] dv, output logic er);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dv;
    @(posedge clk_sys);
    er = reg_error;
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] k);
    reg_q.push_back({k, e});
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic mx(input logic w, input logic [11:0] ad, input logic [1:0] s,
    input logic [31:0] dv, input logic ee, input logic [31:0] e, input logic [31:0] k);
    mem_q.push_back({ee, k, e});
    u_master.xfer(w, ad, s, dv);
  endtask : mx
  // poll for program done, then clear it
  task automatic done();
    int n;
    n = 0;
    do
    begin
      rd(REG_IRQ_STATUS, 32'h0, 32'h0);
      #1;
      n++;
    end
    while (reg_rdata[IRQ_PROG_DONE_BIT] !== 1'b1 && n < 100);
    rd(REG_IRQ_STATUS, 32'h4, 32'h4);
    wr(REG_IRQ_ST_CLR, 32'h4, err);
  endtask : done
  task automatic results();
    // notes never answered mean a transfer or read went missing
    if (reg_q.size() != 0 || mem_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // watcher: compares each answer with the oldest note
  always @(posedge clk_sys)
  begin
    if (rd_d)
    begin
      m = {1'b0, reg_q.pop_front()};
      chk(reg_rdata, m[31:0], m[63:32]);
    end
    if (mem_req.sel && (mem_ready || mem_error))
    begin
      // an answer with no note outstanding is a mismatch
      if (mem_q.size() == 0)
        fail_count++;
      else
      begin
        m = mem_q.pop_front();
        chk({31'h0, mem_error}, {31'h0, m[64]}, 32'h1);
        chk(mem_rdata, m[31:0], m[63:32]);
      end
    end
    rd_d <= reg_rd;
  end
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(57011));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_COMMAND, 32'h0, 32'h7);
    rd(REG_RD_WAIT, {16'h0, RD_WAIT_RESET}, 32'hffff);
    rd(REG_AUTO_PROG, 32'h0, 32'h3);
    rd(REG_IRQ_STATUS, 32'h0, '1);
    rd(REG_IRQ_EN_VIEW, 32'h0, '1);
    rd(REG_IDENTITY, IDENTITY_VALUE, '1);
    rd(12'h100, 32'h0, '1);
    $display("test reset values done");
    repeat (2)
    begin
      d = $urandom;
      a = 12'($urandom_range(59) * 64 + $urandom_range(30) * 2);
      mx(1, a, 1, {d[15:0], d[15:0]}, 0, 0, 0);
      mx(1, a + 12'h2, 1, {d[31:16], d[31:16]}, 0, 0, 0);
      wr(REG_COMMAND, {29'h0, CMD_PROGRAM}, err);
      mx(0, a, 2, 0, 1, 0, 0);
      wr(REG_COMMAND, {29'h0, CMD_PROGRAM}, err);
      chk({31'h0, err}, 32'h1, 32'h1);
      done();
      mx(0, a, 2, 0, 0, d, '1);
      mx(0, a + 12'h1, 0, 0, 0, {24'h0, d[15:8]}, 32'hff);
      #1;
      chk({16'h0, last_word}, {16'h0, d[15:0]}, 32'hffff);
    end
    $display("test command program done");
    mx(1, 12'hf00 + 12'($urandom_range(127) * 2), 1, d, 1, 0, 0);
    $display("test locked rows done");
    wr(REG_AUTO_PROG, {30'h0, AUTO_EACH}, err);
    mx(1, 12'h040, 1, d, 0, 0, 0);
    mx(0, 12'h040, 1, 0, 1, 0, 0);
    done();
    wr(REG_AUTO_PROG, {30'h0, AUTO_ROW_END}, err);
    mx(1, 12'h080, 1, d, 0, 0, 0);
    mx(0, 12'h080, 1, 0, 0, 0, 0);
    mx(1, 12'h0be, 1, ~d, 0, 0, 0);
    mx(0, 12'h080, 2, 0, 1, 0, 0);
    done();
    mx(0, 12'h080, 1, 0, 0, {16'h0, d[15:0]}, 32'hffff);
    wr(REG_AUTO_PROG, 32'h0, err);
    $display("test auto program done");
    wr(REG_IRQ_EN_SET, '1, err);
    rd(REG_IRQ_EN_VIEW, IRQ_MASK, '1);
    wr(REG_IRQ_EN_CLR, 32'h4, err);
    rd(REG_IRQ_EN_VIEW, 32'h8, '1);
    wr(REG_IRQ_ST_SET, 32'h8, err);
    rd(REG_IRQ_STATUS, 32'h8, '1);
    wr(REG_IRQ_ST_CLR, 32'h8, err);
    rd(REG_IRQ_STATUS, 32'h0, '1);
    $display("test irq registers done");
    wr(REG_SUM_START, 32'h20, err);
    wr(REG_SUM_STOP, 32'h20, err);
    rd(REG_DATA_SIG, {16'h0, d[15:0]}, '1);
    rd(REG_IRQ_STATUS, 32'h8, 32'h8);
    wr(REG_IRQ_ST_CLR, 32'h8, err);
    wr(REG_SUM_STOP, 32'h3f, err);
    // a program command during the walk is held off
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= REG_COMMAND;
    reg_wdata <= {29'h0, CMD_PROGRAM};
    @(posedge clk_sys);
    chk({31'h0, reg_wait}, 32'h1, 32'h1);
    reg_wr <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rd(REG_IRQ_STATUS, 32'h8, 32'h8);
    $display("test checksum done");
    rd(REG_WR_WAIT, WR_WAIT_RESET, '1);
    wr(REG_WR_WAIT, 32'h8002_0202, err);
    wr(REG_WR_WAIT, 32'h0001_0101, err);
    rd(REG_WR_WAIT, 32'h8002_0202, '1);
    $display("test timing lock done");
    // let the watcher compare the last read
    repeat (2) @(posedge clk_sys);
    results();
  end
endmodule : eebc_top_bench
bind eebc_top eebc_asserts u_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_error, .reg_wait, .mem_req, .mem_rdata, .mem_ready, .mem_error);
